// *** logic/pc_bank1_pkg.sv ***
// package: register map, reset values and carrier types for the bank-1 register block
// assumes a 25 MHz core clock and a word-indexed classic wishbone slave port
`default_nettype none
package pc_bank1_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_INDIRECT_PORT = 8'h80;
    localparam logic [7:0] IDX_TIMER_CFG = 8'h81;
    localparam logic [7:0] IDX_PC_LOW = 8'h82;
    localparam logic [7:0] IDX_STATUS = 8'h83;
    localparam logic [7:0] IDX_POINTER = 8'h84;
    localparam logic [7:0] IDX_PORTA_DIR = 8'h85;
    localparam logic [7:0] IDX_PORTB_DIR = 8'h86;
    localparam logic [7:0] IDX_PC_HIGH_LATCH = 8'h8a;
    localparam logic [7:0] IDX_IRQ_CONTROL = 8'h8b;
    localparam logic [7:0] IDX_PERIPH_IRQ_EN = 8'h8c;
    localparam logic [7:0] IDX_POWER_STATUS = 8'h8e;
    localparam logic [7:0] IDX_ADC_PIN_CFG = 8'h9f;
    // core sequencing registers
    localparam logic [7:0] IDX_CORE_COMMAND = 8'ha0;
    localparam logic [7:0] IDX_BRANCH_TARGET = 8'ha1;
    localparam logic [7:0] IDX_CORE_STATE = 8'ha2;
    localparam logic [7:0] IDX_WORD_LOW = 8'ha3;
    localparam logic [7:0] IDX_WORD_HIGH = 8'ha4;
    localparam logic [7:0] IDX_PC_HIGH = 8'ha5;
    // implemented-bit masks
    localparam logic [7:0] MASK_PORTA_DIR = 8'h3f;
    localparam logic [7:0] MASK_PC_HIGH_LATCH = 8'h1f;
    localparam logic [7:0] MASK_PERIPH_IRQ_EN = 8'h40;
    localparam logic [7:0] MASK_POWER_STATUS_WR = 8'h07;
    localparam logic [7:0] MASK_ADC_PIN_CFG = 8'h03;
    localparam logic [7:0] MASK_STATUS_WR = 8'he7;
    localparam logic [7:0] MASK_STATUS_KEEP = 8'h07;
    localparam logic [7:0] MASK_IRQ_KEEP = 8'h01;
    // reset values
    localparam logic [7:0] RST_TIMER_CFG = 8'hff;
    localparam logic [7:0] RST_PORTA_DIR = 8'h3f;
    localparam logic [7:0] RST_PORTB_DIR = 8'hff;
    localparam logic [7:0] RST_STATUS_POR = 8'h18;
    localparam logic [7:0] RST_POWER_STATUS_POR = 8'h04;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // program space
    localparam logic [12:0] PC_RESET_VECTOR = 13'h0000;
    localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;
    localparam logic [12:0] PC_IMPL_MASK = 13'h07ff;
    localparam logic [12:0] PC_ONE = 13'h0001;
    // status / control bit positions
    localparam int STATUS_TIMEOUT_BIT = 4;
    localparam int STATUS_POWERDOWN_BIT = 3;
    localparam int IRQ_GLOBAL_EN_BIT = 7;
    // core commands
    localparam logic [2:0] CMD_STEP = 3'h1;
    localparam logic [2:0] CMD_GOTO = 3'h2;
    localparam logic [2:0] CMD_CALL = 3'h3;
    localparam logic [2:0] CMD_RETURN = 3'h4;
    localparam logic [2:0] CMD_IRQ = 3'h5;
    localparam logic [2:0] CMD_NONE = 3'h0;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_FLUSH} seq_state_t;

    // one wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] idx;
        logic [7:0] wdata;
    } wb_req_t;
endpackage : pc_bank1_pkg
`default_nettype wire

// *** logic/pc_bank1_regs.sv ***
// program counter sequencing and bank-1 special register map behind a classic wishbone slave
// assumes a synchronous active-low power-up reset and one-cycle reset event pulses
`default_nettype none
// Overview of operation
// - thirteen-bit program counter covering eight thousand fourteen-bit words
// - counter values beyond implemented program memory wrap into the present range
// - resets start fetch at address zero; accepted interrupts continue at address four
// - upper counter bits only load through the high latch, never written directly
// - shared registers answer at one location regardless of selected bank
// - unimplemented locations and bits read zero and ignore writes
// - external pin and watchdog resets apply the non-power-up reset values
// - two-stage fetch and execute: one cycle per instruction, branches two
// - separate fourteen-bit instruction bus and eight-bit data bus
// - eight-entry hardware return address stack
module pc_bank1_regs (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // non-power-up reset events, one-cycle pulses
    input wire logic i_external_reset_pin,
    input wire logic i_watchdog_reset,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_sel,
    input wire logic [9:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    // instruction bus
    output logic [12:0] o_prog_addr,
    output logic o_prog_fetch,
    input wire logic [13:0] i_prog_word
);
    typedef struct packed {
        // bus answer
        logic ack;
        logic [7:0] rdata;
        // counter, instruction latch and sequencer
        logic [12:0] pc;
        logic fetch;
        logic [13:0] word;
        pc_bank1_pkg::seq_state_t seq;
        // return stack; a ninth push overwrites the oldest entry
        logic [7:0][12:0] stack;
        logic [2:0] sp;
        logic [3:0] depth;
        // bank-1 registers
        logic [7:0] timer_cfg;
        logic [7:0] status;
        logic [7:0] pointer;
        logic [7:0] porta_dir;
        logic [7:0] portb_dir;
        logic [7:0] pc_high_latch;
        logic [7:0] irq_control;
        logic [7:0] periph_irq_en;
        logic [7:0] power_status;
        logic [7:0] adc_pin_cfg;
        // own sequencing register and indirect data memory
        logic [7:0] branch_target;
        logic [127:0][7:0] data_mem;
    } state_t;

    // registered state and its next value
    state_t state_reg;
    state_t state_next;
    // decoded bus request
    pc_bank1_pkg::wb_req_t req;
    logic [7:0] bank1_idx;
    logic take;
    logic wr;
    logic [2:0] cmd;
    logic [12:0] target;

    // wrap a counter value into implemented program memory
    function automatic logic [12:0] wrap_addr(input logic [12:0] a);
        wrap_addr = a & pc_bank1_pkg::PC_IMPL_MASK;
    endfunction : wrap_addr

    // stack depth after a push, stops at eight
    function automatic logic [3:0] depth_up(input logic [3:0] d);
        depth_up = (d == 4'd8) ? 4'd8 : d + 4'd1;
    endfunction : depth_up

    // stack depth after a pop, stops at zero
    function automatic logic [3:0] depth_down(input logic [3:0] d);
        depth_down = (d == 4'd0) ? 4'd0 : d - 4'd1;
    endfunction : depth_down

    // index of the bank-1 copy of a location
    function automatic logic [7:0] bank1_copy(input logic [7:0] idx);
        bank1_copy = {1'b1, idx[6:0]};
    endfunction : bank1_copy

    // shared locations answer in either bank
    function automatic logic is_shared(input logic [7:0] idx);
        logic [7:0] b;
        b = bank1_copy(idx);
        is_shared = (b == pc_bank1_pkg::IDX_INDIRECT_PORT) || (b == pc_bank1_pkg::IDX_PC_LOW)
            || (b == pc_bank1_pkg::IDX_STATUS) || (b == pc_bank1_pkg::IDX_POINTER)
            || (b == pc_bank1_pkg::IDX_PC_HIGH_LATCH) || (b == pc_bank1_pkg::IDX_IRQ_CONTROL);
    endfunction : is_shared

    // gather the bus request
    always_comb
    begin
        req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel,
                idx: i_wb_adr[9:2], wdata: i_wb_dat[7:0]};
        bank1_idx = is_shared(req.idx) ? bank1_copy(req.idx) : req.idx;
        // one take per request: an ack in flight blocks a second
        take = req.cyc && req.stb && !state_reg.ack;
        wr = take && req.we && req.sel[0];
        cmd = (wr && (bank1_idx == pc_bank1_pkg::IDX_CORE_COMMAND)) ? req.wdata[2:0] : pc_bank1_pkg::CMD_NONE;
        target = {state_reg.pc_high_latch[4:0], state_reg.branch_target};
    end

    // next state
    always_comb
    begin
        state_next = state_reg;
        state_next.ack = take;
        state_next.fetch = 1'b0;

        // instruction latch, fourteen bits wide
        if (state_reg.fetch)
        begin
            state_next.word = i_prog_word;
        end

        // register reads; unmapped and unimplemented bits give zero
        if (take)
        begin
            case (bank1_idx)
                pc_bank1_pkg::IDX_INDIRECT_PORT: state_next.rdata = state_reg.data_mem[state_reg.pointer[6:0]];
                pc_bank1_pkg::IDX_TIMER_CFG: state_next.rdata = state_reg.timer_cfg;
                pc_bank1_pkg::IDX_PC_LOW: state_next.rdata = state_reg.pc[7:0];
                pc_bank1_pkg::IDX_STATUS: state_next.rdata = state_reg.status;
                pc_bank1_pkg::IDX_POINTER: state_next.rdata = state_reg.pointer;
                pc_bank1_pkg::IDX_PORTA_DIR: state_next.rdata = state_reg.porta_dir;
                pc_bank1_pkg::IDX_PORTB_DIR: state_next.rdata = state_reg.portb_dir;
                pc_bank1_pkg::IDX_PC_HIGH_LATCH: state_next.rdata = state_reg.pc_high_latch;
                pc_bank1_pkg::IDX_IRQ_CONTROL: state_next.rdata = state_reg.irq_control;
                pc_bank1_pkg::IDX_PERIPH_IRQ_EN: state_next.rdata = state_reg.periph_irq_en;
                pc_bank1_pkg::IDX_POWER_STATUS: state_next.rdata = state_reg.power_status;
                pc_bank1_pkg::IDX_ADC_PIN_CFG: state_next.rdata = state_reg.adc_pin_cfg;
                // own registers: branch target, core state, fetched word, counter high
                pc_bank1_pkg::IDX_BRANCH_TARGET: state_next.rdata = state_reg.branch_target;
                pc_bank1_pkg::IDX_CORE_STATE: state_next.rdata = {3'b000, state_reg.seq == pc_bank1_pkg::SEQ_FLUSH,
                                                                  state_reg.depth};
                pc_bank1_pkg::IDX_WORD_LOW: state_next.rdata = state_reg.word[7:0];
                pc_bank1_pkg::IDX_WORD_HIGH: state_next.rdata = {2'b00, state_reg.word[13:8]};
                pc_bank1_pkg::IDX_PC_HIGH: state_next.rdata = {3'b000, state_reg.pc[12:8]};
                default: state_next.rdata = pc_bank1_pkg::RST_ZERO;
            endcase
        end

        // register writes, masked to implemented bits
        // read-only and unmapped indices fall to the default and change nothing
        if (wr)
        begin
            case (bank1_idx)
                pc_bank1_pkg::IDX_INDIRECT_PORT: state_next.data_mem[state_reg.pointer[6:0]] = req.wdata;
                pc_bank1_pkg::IDX_TIMER_CFG: state_next.timer_cfg = req.wdata;
                pc_bank1_pkg::IDX_STATUS: state_next.status = (state_reg.status & ~pc_bank1_pkg::MASK_STATUS_WR)
                    | (req.wdata & pc_bank1_pkg::MASK_STATUS_WR);
                pc_bank1_pkg::IDX_POINTER: state_next.pointer = req.wdata;
                pc_bank1_pkg::IDX_PORTA_DIR: state_next.porta_dir = req.wdata & pc_bank1_pkg::MASK_PORTA_DIR;
                pc_bank1_pkg::IDX_PORTB_DIR: state_next.portb_dir = req.wdata;
                pc_bank1_pkg::IDX_PC_HIGH_LATCH: state_next.pc_high_latch = req.wdata & pc_bank1_pkg::MASK_PC_HIGH_LATCH;
                pc_bank1_pkg::IDX_IRQ_CONTROL: state_next.irq_control = req.wdata;
                pc_bank1_pkg::IDX_PERIPH_IRQ_EN: state_next.periph_irq_en = req.wdata & pc_bank1_pkg::MASK_PERIPH_IRQ_EN;
                pc_bank1_pkg::IDX_POWER_STATUS: state_next.power_status = req.wdata & pc_bank1_pkg::MASK_POWER_STATUS_WR;
                pc_bank1_pkg::IDX_ADC_PIN_CFG: state_next.adc_pin_cfg = req.wdata & pc_bank1_pkg::MASK_ADC_PIN_CFG;
                // branch target low byte for goto and call
                pc_bank1_pkg::IDX_BRANCH_TARGET: state_next.branch_target = req.wdata;
                default: state_next.rdata = state_next.rdata;
            endcase
        end

        // fetch sequencer: straight-line step is one cycle, any branch flushes one fetch
        // commands during the flush cycle are dropped; software polls core state
        case (state_reg.seq)
            pc_bank1_pkg::SEQ_IDLE:
            begin
                // low byte write is a computed jump within the latched page
                if (wr && (bank1_idx == pc_bank1_pkg::IDX_PC_LOW))
                begin
                    state_next.pc = wrap_addr({state_reg.pc_high_latch[4:0], req.wdata});
                    state_next.seq = pc_bank1_pkg::SEQ_FLUSH;
                end
                else
                begin
                    case (cmd)
                        // straight-line fetch of the next word
                        pc_bank1_pkg::CMD_STEP:
                        begin
                            state_next.pc = wrap_addr(state_reg.pc + pc_bank1_pkg::PC_ONE);
                            state_next.fetch = 1'b1;
                        end
                        // jump to latch page and branch target
                        pc_bank1_pkg::CMD_GOTO:
                        begin
                            state_next.pc = wrap_addr(target);
                            state_next.seq = pc_bank1_pkg::SEQ_FLUSH;
                        end
                        // push the return address, then jump
                        pc_bank1_pkg::CMD_CALL:
                        begin
                            state_next.stack[state_reg.sp] = wrap_addr(state_reg.pc + pc_bank1_pkg::PC_ONE);
                            state_next.sp = state_reg.sp + 3'd1;
                            state_next.depth = depth_up(state_reg.depth);
                            state_next.pc = wrap_addr(target);
                            state_next.seq = pc_bank1_pkg::SEQ_FLUSH;
                        end
                        // pop the return address
                        pc_bank1_pkg::CMD_RETURN:
                        begin
                            state_next.sp = state_reg.sp - 3'd1;
                            state_next.depth = depth_down(state_reg.depth);
                            state_next.pc = state_reg.stack[state_reg.sp - 3'd1];
                            state_next.seq = pc_bank1_pkg::SEQ_FLUSH;
                        end
                        // push the current counter, go to the vector
                        pc_bank1_pkg::CMD_IRQ:
                        begin
                            state_next.stack[state_reg.sp] = state_reg.pc;
                            state_next.sp = state_reg.sp + 3'd1;
                            state_next.depth = depth_up(state_reg.depth);
                            state_next.pc = pc_bank1_pkg::PC_IRQ_VECTOR;
                            state_next.irq_control[pc_bank1_pkg::IRQ_GLOBAL_EN_BIT] = 1'b0;
                            state_next.seq = pc_bank1_pkg::SEQ_FLUSH;
                        end
                        default: state_next.seq = pc_bank1_pkg::SEQ_IDLE;
                    endcase
                end
            end
            pc_bank1_pkg::SEQ_FLUSH:
            begin
                // second branch cycle refetches at the new counter
                state_next.fetch = 1'b1;
                state_next.seq = pc_bank1_pkg::SEQ_IDLE;
            end
            default: state_next.seq = pc_bank1_pkg::SEQ_IDLE;
        endcase

        // non-power-up resets: counter and bank selects cleared, most contents kept
        if (i_external_reset_pin || i_watchdog_reset)
        begin
            state_next.pc = pc_bank1_pkg::PC_RESET_VECTOR;
            // the flush cycle after a reset refetches address zero
            state_next.seq = pc_bank1_pkg::SEQ_FLUSH;
            state_next.fetch = 1'b0;
            // stack emptied
            state_next.sp = 3'd0;
            state_next.depth = 4'd0;
            // configuration back to reset values
            state_next.timer_cfg = pc_bank1_pkg::RST_TIMER_CFG;
            state_next.porta_dir = pc_bank1_pkg::RST_PORTA_DIR;
            state_next.portb_dir = pc_bank1_pkg::RST_PORTB_DIR;
            state_next.pc_high_latch = pc_bank1_pkg::RST_ZERO;
            state_next.periph_irq_en = pc_bank1_pkg::RST_ZERO;
            state_next.adc_pin_cfg = pc_bank1_pkg::RST_ZERO;
            // control and status keep only their sticky bits
            state_next.irq_control = state_reg.irq_control & pc_bank1_pkg::MASK_IRQ_KEEP;
            state_next.status = state_reg.status & pc_bank1_pkg::MASK_STATUS_KEEP;
            state_next.status[pc_bank1_pkg::STATUS_TIMEOUT_BIT] = i_watchdog_reset ? 1'b0
                : state_reg.status[pc_bank1_pkg::STATUS_TIMEOUT_BIT];
            state_next.status[pc_bank1_pkg::STATUS_POWERDOWN_BIT] = i_watchdog_reset ? 1'b1
                : state_reg.status[pc_bank1_pkg::STATUS_POWERDOWN_BIT];
        end
    end

    // state register with power-up values
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            // clear everything, then load the non-zero power-up values
            state_reg <= '0;
            state_reg.pc <= pc_bank1_pkg::PC_RESET_VECTOR;
            state_reg.seq <= pc_bank1_pkg::SEQ_FLUSH;
            state_reg.timer_cfg <= pc_bank1_pkg::RST_TIMER_CFG;
            state_reg.status <= pc_bank1_pkg::RST_STATUS_POR;
            state_reg.porta_dir <= pc_bank1_pkg::RST_PORTA_DIR;
            state_reg.portb_dir <= pc_bank1_pkg::RST_PORTB_DIR;
            state_reg.power_status <= pc_bank1_pkg::RST_POWER_STATUS_POR;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops
    assign o_wb_ack = state_reg.ack;
    assign o_wb_dat = {24'h00_0000, state_reg.rdata};
    assign o_prog_addr = state_reg.pc;
    assign o_prog_fetch = state_reg.fetch;
endmodule : pc_bank1_regs
`default_nettype wire

// *** verification/pc_bank1_regs_asserts.sv ***
// checker: bus answer timing and counter sequencing of the bank-1 register block
// assumes it is bound into pc_bank1_regs and sees only that module's ports
`default_nettype none
module pc_bank1_regs_asserts (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // reset events
    input wire logic i_external_reset_pin,
    input wire logic i_watchdog_reset,
    // wishbone
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_sel,
    input wire logic [9:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic [31:0] o_wb_dat,
    // instruction bus
    input wire logic [12:0] o_prog_addr,
    input wire logic o_prog_fetch,
    input wire logic [13:0] i_prog_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cmd_take;
    logic [1:0] quiet_reg;
    // command write taken this edge; quiet_reg keeps flush cycles after resets out
    assign cmd_take = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_dat[7:3] == 5'h00
        && i_wb_adr[9:2] == pc_bank1_pkg::IDX_CORE_COMMAND && quiet_reg == 2'h3 && !i_external_reset_pin
        && !i_watchdog_reset;
    // cycles since the last reset of any kind, saturating
    always_ff @(posedge i_clk_sys)
        if (!i_resetn || i_external_reset_pin || i_watchdog_reset)
            quiet_reg <= 2'h0;
        else if (quiet_reg != 2'h3)
            quiet_reg <= quiet_reg + 2'h1;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    chk_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack one cycle after a request");
    chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    chk_data_width: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
        else $error("read data beyond eight bits");
    chk_adc_bits: assert property (o_wb_ack && $past(i_wb_adr) == {pc_bank1_pkg::IDX_ADC_PIN_CFG, 2'h0}
        |-> o_wb_dat[7:2] == 6'h00)
        else $error("unimplemented converter bits read back set");
    chk_addr_wrapped: assert property (o_prog_addr[12:11] == 2'h0)
        else $error("counter outside implemented memory");
    chk_ext_vector: assert property (i_external_reset_pin |=> o_prog_addr == 13'h0000 ##[0:1] o_prog_fetch)
        else $error("pin reset did not restart at zero");
    chk_wd_vector: assert property (i_watchdog_reset |=> o_prog_addr == 13'h0000 ##[0:1] o_prog_fetch)
        else $error("watchdog reset did not restart at zero");
    chk_step_fetch: assert property (cmd_take && i_wb_dat[2:0] == pc_bank1_pkg::CMD_STEP
        |=> o_prog_fetch && o_prog_addr == (($past(o_prog_addr) + 13'h0001) & 13'h07ff))
        else $error("step did not fetch the next word");
    chk_branch_bubble: assert property (cmd_take && i_wb_dat[2:0] == pc_bank1_pkg::CMD_GOTO
        |=> !o_prog_fetch ##1 o_prog_fetch)
        else $error("branch not two cycles");
    chk_irq_vector: assert property (cmd_take && i_wb_dat[2:0] == pc_bank1_pkg::CMD_IRQ
        |=> o_prog_addr == 13'h0004)
        else $error("interrupt did not go to four");
endmodule : pc_bank1_regs_asserts

bind pc_bank1_regs pc_bank1_regs_asserts i_pc_bank1_regs_asserts (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_external_reset_pin(i_external_reset_pin), .i_watchdog_reset(i_watchdog_reset), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_sel(i_wb_sel), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_prog_addr(o_prog_addr), .o_prog_fetch(o_prog_fetch),
    .i_prog_word(i_prog_word));
`default_nettype wire

// *** verification/test_pc_bank1_regs.sv ***
// testbench: register map, counter sequencing and resets of the bank-1 register block
// assumes a 25 MHz clock and the one-cycle wishbone answer of the slave port
`default_nettype none
module test_pc_bank1_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic i_external_reset_pin = 1'b0;
    logic i_watchdog_reset = 1'b0;
    logic i_wb_cyc = 1'b0;
    logic i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0;
    logic [3:0] i_wb_sel = 4'h0;
    logic [9:0] i_wb_adr = 10'h000;
    logic [31:0] i_wb_dat = 32'h0000_0000;
    logic [13:0] i_prog_word = 14'h0000;
    logic o_wb_ack;
    logic [31:0] o_wb_dat;
    logic [12:0] o_prog_addr;
    logic o_prog_fetch;
    logic [31:0] rd_val;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    localparam logic [7:0] POR_IDX [12] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h8a, 8'h8b, 8'h8c, 8'h8e,
        8'h9f, 8'h87};
    localparam logic [7:0] POR_VAL [12] = '{8'hff, 8'h00, 8'h18, 8'h00, 8'h3f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h04,
        8'h00, 8'h00};
    localparam logic [7:0] WR_IDX [6] = '{8'h85, 8'h8a, 8'h8c, 8'h9f, 8'h87, 8'h9e};
    localparam logic [7:0] WR_EXP [6] = '{8'h3f, 8'h1f, 8'h40, 8'h03, 8'h00, 8'h00};
    // values expected after the pin reset in the main sequence
    localparam logic [7:0] NPR_IDX [9] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h8a, 8'h8b, 8'h8c, 8'h9f, 8'h81};
    localparam logic [7:0] NPR_VAL [9] = '{8'h1f, 8'h25, 8'h3f, 8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 8'hff};

    // 40 ns core clock
    always #20 i_clk_sys = ~i_clk_sys;

    pc_bank1_regs i_pc_bank1_regs (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_external_reset_pin(i_external_reset_pin), .i_watchdog_reset(i_watchdog_reset), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_sel(i_wb_sel), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat),
        .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_prog_addr(o_prog_addr), .o_prog_fetch(o_prog_fetch),
        .i_prog_word(i_prog_word));

    task automatic results();
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    // hang guard
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_sel <= 4'h1;
        i_wb_adr <= {idx, 2'h0};
        i_wb_dat <= {24'h00_0000, d};
        do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
        rd_val = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check(rd_val, {24'h00_0000, exp});
    endtask : rd

    // one-cycle reset event, then the counter must sit at zero
    task automatic pulse(input logic wd);
        @(posedge i_clk_sys);
        i_watchdog_reset <= wd;
        i_external_reset_pin <= !wd;
        @(posedge i_clk_sys);
        i_watchdog_reset <= 1'b0;
        i_external_reset_pin <= 1'b0;
        @(posedge i_clk_sys);
        check({19'h0_0000, o_prog_addr}, 32'h0000_0000);
    endtask : pulse

    // main sequence
    initial
    begin
        repeat (10) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        for (int i = 0; i < 12; i++) rd(POR_IDX[i], POR_VAL[i]);
        for (int i = 0; i < 6; i++)
        begin
            wb(1'b1, WR_IDX[i], 8'hff);
            rd(WR_IDX[i], WR_EXP[i]);
        end
        wb(1'b1, 8'h84, 8'h25);
        rd(8'h04, 8'h25);
        wb(1'b1, 8'h80, 8'h5a);
        wb(1'b1, 8'h84, 8'h26);
        rd(8'h00, 8'h00);
        wb(1'b1, 8'h04, 8'h25);
        rd(8'h80, 8'h5a);
        wb(1'b1, 8'h8a, 8'h1f);
        wb(1'b1, 8'ha1, 8'hf0);
        wb(1'b1, 8'ha0, 8'h02);
        check({19'h0_0000, o_prog_addr}, 32'h0000_07f0);
        wb(1'b1, 8'ha5, 8'h00);
        rd(8'ha5, 8'h07);
        i_prog_word <= 14'h2d5a;
        wb(1'b1, 8'ha1, 8'hff);
        wb(1'b1, 8'ha0, 8'h02);
        wb(1'b1, 8'ha0, 8'h01);
        check({19'h0_0000, o_prog_addr}, 32'h0000_0000);
        rd(8'ha3, 8'h5a);
        rd(8'ha4, 8'h2d);
        wb(1'b1, 8'h8a, 8'h00);
        wb(1'b1, 8'ha1, 8'h40);
        for (int i = 0; i < 8; i++) wb(1'b1, 8'ha0, 8'h03);
        rd(8'ha2, 8'h08);
        wb(1'b1, 8'ha0, 8'h04);
        check({19'h0_0000, o_prog_addr}, 32'h0000_0041);
        rd(8'ha2, 8'h07);
        wb(1'b1, 8'h8b, 8'h81);
        wb(1'b1, 8'ha0, 8'h05);
        check({19'h0_0000, o_prog_addr}, 32'h0000_0004);
        rd(8'h8b, 8'h01);
        wb(1'b1, 8'h02, 8'h9c);
        check({19'h0_0000, o_prog_addr}, 32'h0000_009c);
        wb(1'b1, 8'h81, 8'h00);
        wb(1'b1, 8'h85, 8'h00);
        wb(1'b1, 8'h8a, 8'h1f);
        wb(1'b1, 8'h8e, 8'h05);
        wb(1'b1, 8'h83, 8'h27);
        pulse(1'b0);
        for (int i = 0; i < 9; i++) rd(NPR_IDX[i], NPR_VAL[i]);
        rd(8'h8e, 8'h05);
        wb(1'b1, 8'h83, 8'h27);
        pulse(1'b1);
        rd(8'h83, 8'h0f);
        results();
    end
endmodule : test_pc_bank1_regs
`default_nettype wire
